// File: src/cps_consts.svh
// What this block does
// - cam output is on while axis position lies between on and off points.
// - on point above off point keeps output on across the rollover wrap.
// - entry with on or off point outside 30-bit signed range is refused.
// - every cam output is recomputed once per servo tick.
// - module select zero drives only the status bit, no physical point.
// - inhibit clears status and physical output and skips evaluation.
// - equal on and off points give no output but still take evaluation time.
// - codes 100 to 232 all set the drive_out bit at the entry's channel index; selected axis is latched but unused.
// - status output shows current logical cam state of each entry.
// - 1 to 32 independent cam entries, each with its own channel index.
`ifndef CPS_CONSTS_SVH
`define CPS_CONSTS_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define CPS_REG_CTRL      12'h000
`define CPS_REG_ENTRY_SEL 12'h004
`define CPS_REG_ON_POS    12'h008
`define CPS_REG_OFF_POS   12'h00C
`define CPS_REG_MODULE    12'h010
`define CPS_REG_COMMIT    12'h014
`define CPS_REG_STATUS    12'h018
`define CPS_REG_VALID     12'h01C
`define CPS_REG_POINTS_A  12'h020
`define CPS_REG_POINTS_B  12'h024
`define CPS_REG_DRIVE     12'h028
`define CPS_REG_POSITION  12'h02C
`define CPS_REG_ROLLOVER  12'h030
// ----------------------------------------
// fields and limits
// ----------------------------------------
`define CPS_ENTRIES       32
`define CPS_CTRL_EN_BIT   0
`define CPS_MOD_INH_BIT   16
`define CPS_POS_MIN       32'shE0000000
`define CPS_POS_MAX       32'sh1FFFFFFF
`define CPS_DRIVE_SEL     8'h64
`define CPS_DRIVE_LAST    8'hE8
`define CPS_RESET_WORD    32'h00000000
`endif

// File: src/cps_pkg.sv
package cps_pkg;
  typedef logic signed [31:0] cps_pos_t;
  typedef enum logic [1:0] {CPS_IDLE, CPS_EVAL, CPS_DONE} cps_state_e;
endpackage

// File: src/cps_cam_mem.sv
`timescale 1ns/1ps
module cps_cam_mem (
  input  wire logic        pclk,
  input  wire logic [4:0]  waddr,
  input  wire logic        we,
  input  wire logic [81:0] wdata,
  input  wire logic [4:0]  raddr,
  output logic      [81:0] rdata
);
  logic [81:0] mem [0:31];
  // write and registered read; no reset, validity lives in flops outside
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// File: src/cps_top.sv
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "cps_consts.svh"
module cps_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        servo_tick,
  input  wire logic [31:0] axis_position,
  input  wire logic [7:0]  selected_axis,
  output logic      [31:0] cam_status,
  output logic      [31:0] points_a,
  output logic      [31:0] points_b,
  output logic      [31:0] drive_out,
  output logic             eval_busy
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] tick_sync;
  logic       tick_rise;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_sync <= 3'h0;
    end else begin
      tick_sync <= {tick_sync[1:0], servo_tick};
    end
  end
  assign tick_rise = tick_sync[1] & ~tick_sync[2];

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic             enable, next_enable;
  logic [4:0]       entry_sel, next_entry_sel;
  cps_pkg::cps_pos_t on_pos, next_on_pos, off_pos, next_off_pos, rollover, next_rollover;
  logic [16:0]      module_word, next_module_word;
  logic [31:0]      valid, next_valid;
  logic [31:0]      inhibit, next_inhibit;
  logic             commit_ok, next_commit_ok;
  logic             wr, rd;
  logic             in_range;

  assign wr      = psel & penable & pwrite;
  assign rd      = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  // out-of-range on/off leaves the entry unwritten and the ok flag clear
  assign in_range = ($signed(on_pos) >= $signed(`CPS_POS_MIN)) && ($signed(on_pos) <= $signed(`CPS_POS_MAX)) &&
                    ($signed(off_pos) >= $signed(`CPS_POS_MIN)) && ($signed(off_pos) <= $signed(`CPS_POS_MAX));

  always_comb begin
    next_enable      = enable;
    next_entry_sel   = entry_sel;
    next_on_pos      = on_pos;
    next_off_pos     = off_pos;
    next_rollover    = rollover;
    next_module_word = module_word;
    next_valid       = valid;
    next_inhibit     = inhibit;
    next_commit_ok   = commit_ok;
    if (wr) begin
      unique case (paddr)
        `CPS_REG_CTRL:      next_enable      = pwdata[`CPS_CTRL_EN_BIT];
        `CPS_REG_ENTRY_SEL: next_entry_sel   = pwdata[4:0];
        `CPS_REG_ON_POS:    next_on_pos      = pwdata;
        `CPS_REG_OFF_POS:   next_off_pos     = pwdata;
        `CPS_REG_MODULE:    next_module_word = pwdata[16:0];
        `CPS_REG_ROLLOVER:  next_rollover    = pwdata;
        `CPS_REG_COMMIT: begin
          next_commit_ok = in_range;
          if (in_range) begin
            next_valid[entry_sel]   = 1'b1;
            next_inhibit[entry_sel] = module_word[`CPS_MOD_INH_BIT];
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable      <= 1'b0;
      entry_sel   <= 5'h00;
      on_pos      <= `CPS_RESET_WORD;
      off_pos     <= `CPS_RESET_WORD;
      rollover    <= `CPS_RESET_WORD;
      module_word <= 17'h00000;
      valid       <= `CPS_RESET_WORD;
      inhibit     <= `CPS_RESET_WORD;
      commit_ok   <= 1'b0;
    end else begin
      enable      <= next_enable;
      entry_sel   <= next_entry_sel;
      on_pos      <= next_on_pos;
      off_pos     <= next_off_pos;
      rollover    <= next_rollover;
      module_word <= next_module_word;
      valid       <= next_valid;
      inhibit     <= next_inhibit;
      commit_ok   <= next_commit_ok;
    end
  end

  // ----------------------------------------
  // entry memory and evaluation sweep
  // ----------------------------------------
  logic [81:0]            mem_rdata;
  logic [4:0]             idx, next_idx, eval_idx, next_eval_idx;
  logic                   rd_valid, next_rd_valid;
  cps_pkg::cps_state_e    state, next_state;
  cps_pkg::cps_pos_t      pos_latch, next_pos_latch, wrapped;
  logic [7:0]             axis_latch, next_axis_latch;
  logic [31:0]            next_cam_status, next_points_a, next_points_b, next_drive_out;
  logic [31:0]            next_prdata;

  // one entry word: on[31:0], off[63:32], module code[71:64], channel_index[76:72], spare
  cps_cam_mem u_mem (
    .pclk  (pclk),
    .waddr (entry_sel),
    .we    (wr && paddr == `CPS_REG_COMMIT && in_range),
    .wdata ({5'h00, module_word[12:8], module_word[7:0], off_pos, on_pos}),
    .raddr (idx),
    .rdata (mem_rdata)
  );

  // position inside the rollover cycle; one rollover length is taken off an axis at or above it
  assign wrapped = ($signed(rollover) > 0 && $signed(pos_latch) >= $signed(rollover))
                 ? pos_latch - rollover : pos_latch;

  // ----------------------------------------
  // point bank select
  // ----------------------------------------
  // bank a is fixed to module code 2; any other nonzero non-drive code lands in bank b
  logic [7:0] points_sel_a;
  assign points_sel_a = 8'h02;

  always_comb begin
    logic                    hit;
    logic [7:0]              code;
    logic [4:0]              chan;
    cps_pkg::cps_pos_t       onp, offp;
    hit  = 1'b0;
    code = mem_rdata[71:64];
    chan = mem_rdata[76:72];
    onp  = mem_rdata[31:0];
    offp = mem_rdata[63:32];
    next_state      = state;
    next_idx        = idx;
    next_eval_idx   = eval_idx;
    next_rd_valid   = 1'b0;
    next_pos_latch  = pos_latch;
    next_axis_latch = axis_latch;
    next_cam_status = cam_status;
    next_points_a   = points_a;
    next_points_b   = points_b;
    next_drive_out  = drive_out;
    unique case (state)
      cps_pkg::CPS_IDLE: begin
        if (tick_rise && enable) begin
          next_state      = cps_pkg::CPS_EVAL;
          next_idx        = 5'h00;
          // first entry word is read out one cycle into the sweep
          next_pos_latch  = axis_position;
          next_axis_latch = selected_axis;
        end
      end
      cps_pkg::CPS_EVAL: begin
        next_rd_valid = 1'b1;
        next_eval_idx = idx;
        next_idx      = idx + 5'h01;
        if (idx == 5'h1F) begin
          next_state = cps_pkg::CPS_DONE;
        end
      end
      cps_pkg::CPS_DONE: begin
        next_state = cps_pkg::CPS_IDLE;
      end
    endcase
    // data from memory lags the address by one cycle
    if (rd_valid && valid[eval_idx]) begin
      if (inhibit[eval_idx]) begin
        // inhibited entries skip the compare; their point is forced off
        hit = 1'b0;
      end else if (onp < offp) begin
        hit = (wrapped >= onp) && (wrapped < offp);
      end else if (onp > offp) begin
        hit = (wrapped >= onp) || (wrapped < offp);
      end else begin
        hit = 1'b0;
      end
      next_cam_status[eval_idx] = hit;
      if (code == 8'h00) begin
        // no physical point touched
      end else if (code >= `CPS_DRIVE_SEL && code <= `CPS_DRIVE_LAST) begin
        next_drive_out[chan] = hit;
      end else if (code == points_sel_a) begin
        next_points_a[chan] = hit;
      end else begin
        next_points_b[chan] = hit;
      end
    end else if (rd_valid) begin
      next_cam_status[eval_idx] = 1'b0;
    end
  end

  always_comb begin
    next_prdata = 32'h00000000;
    if (rd) begin
      unique case (paddr)
        `CPS_REG_CTRL:      next_prdata = {31'h0, enable};
        `CPS_REG_ENTRY_SEL: next_prdata = {27'h0, entry_sel};
        `CPS_REG_ON_POS:    next_prdata = on_pos;
        `CPS_REG_OFF_POS:   next_prdata = off_pos;
        `CPS_REG_MODULE:    next_prdata = {15'h0, module_word};
        `CPS_REG_COMMIT:    next_prdata = {31'h0, commit_ok};
        `CPS_REG_STATUS:    next_prdata = cam_status;
        `CPS_REG_VALID:     next_prdata = valid;
        `CPS_REG_POINTS_A:  next_prdata = points_a;
        `CPS_REG_POINTS_B:  next_prdata = points_b;
        `CPS_REG_DRIVE:     next_prdata = drive_out;
        `CPS_REG_POSITION:  next_prdata = pos_latch;
        `CPS_REG_ROLLOVER:  next_prdata = rollover;
        default:            next_prdata = 32'h00000000;
      endcase
    end
  end

  assign prdata    = next_prdata;
  assign pslverr   = 1'b0;
  assign eval_busy = (state != cps_pkg::CPS_IDLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= cps_pkg::CPS_IDLE;
      idx        <= 5'h00;
      eval_idx   <= 5'h00;
      rd_valid   <= 1'b0;
      pos_latch  <= `CPS_RESET_WORD;
      axis_latch <= 8'h00;
      cam_status <= `CPS_RESET_WORD;
      points_a   <= `CPS_RESET_WORD;
      points_b   <= `CPS_RESET_WORD;
      drive_out  <= `CPS_RESET_WORD;
    end else begin
      state      <= next_state;
      idx        <= next_idx;
      eval_idx   <= next_eval_idx;
      rd_valid   <= next_rd_valid;
      pos_latch  <= next_pos_latch;
      axis_latch <= next_axis_latch;
      cam_status <= next_cam_status;
      points_a   <= next_points_a;
      points_b   <= next_points_b;
      drive_out  <= next_drive_out;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_RANGE_REFUSE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == `CPS_REG_COMMIT && !in_range) |=> !commit_ok) else $error("bad range committed");
  AST_TICK_SWEEP: assert property (@(posedge pclk) disable iff (!presetn)
    (state == cps_pkg::CPS_IDLE && tick_rise && enable) |=> eval_busy [*8]) else $error("sweep stopped");
  AST_SWEEP_END: assert property (@(posedge pclk) disable iff (!presetn)
    (state == cps_pkg::CPS_IDLE && tick_rise && enable) |-> ##[30:36] !eval_busy) else $error("sweep overran");
  AST_INHIBIT_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_valid && inhibit[eval_idx]) |=> !cam_status[$past(eval_idx)]) else $error("inhibited entry on");
  AST_INHIBIT_POINT: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_valid && valid[eval_idx] && inhibit[eval_idx] && mem_rdata[71:64] == points_sel_a)
    |=> !points_a[$past(mem_rdata[76:72])]) else $error("inhibited point on");
  AST_EQUAL_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_valid && valid[eval_idx] && mem_rdata[31:0] == mem_rdata[63:32]) |=> !cam_status[$past(eval_idx)])
    else $error("equal points gave output");
  AST_RESET_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
    (valid == 32'h00000000) |-> (cam_status == 32'h00000000)) else $error("output before config");
  AST_STATUS_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (!rd_valid) |=> $stable(cam_status)) else $error("status changed outside sweep");
  AST_SLOT_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_valid && mem_rdata[71:64] == 8'h00) |=> ($stable(points_a) && $stable(points_b) && $stable(drive_out)))
    else $error("slot zero touched a point");
  AST_DRIVE_MAP: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_valid && valid[eval_idx] && mem_rdata[71:64] >= `CPS_DRIVE_SEL && mem_rdata[71:64] <= `CPS_DRIVE_LAST)
    |=> (drive_out[$past(mem_rdata[76:72])] == cam_status[$past(eval_idx)])) else $error("drive point mismatch");

  // ----------------------------------------
  // coverage
  // ----------------------------------------
  COV_SWEEP: cover property (@(posedge pclk) disable iff (!presetn) state == cps_pkg::CPS_DONE);
  COV_INHIBIT: cover property (@(posedge pclk) disable iff (!presetn)
    rd_valid && valid[eval_idx] && inhibit[eval_idx]);
  COV_DRIVE_HIT: cover property (@(posedge pclk) disable iff (!presetn)
    drive_out != 32'h00000000);
  COV_WRAP_HIT: cover property (@(posedge pclk) disable iff (!presetn)
    rd_valid && mem_rdata[31:0] > mem_rdata[63:32] && valid[eval_idx]);
  COV_COMMIT_BAD: cover property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == `CPS_REG_COMMIT && !in_range);
endmodule

// File: verification/cps_axis_src.sv
`timescale 1ns/1ps
module cps_axis_src (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        fire,
  input  wire logic [31:0] target_pos,
  output logic             servo_tick,
  output logic      [31:0] axis_position
);
  logic [1:0] hold;
  // ----------------------------------------
  // position source and servo tick
  // ----------------------------------------
  // position moves only at a tick, so a sweep never sees a half-updated value
  // tick held three cycles so the two-flop sync cannot miss it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold          <= 2'h0;
      servo_tick    <= 1'b0;
      axis_position <= 32'h00000000;
    end else begin
      if (fire) begin
        axis_position <= target_pos;
        hold          <= 2'h3;
      end else if (hold != 2'h0) begin
        hold <= hold - 2'h1;
      end
      servo_tick <= fire || (hold > 2'h1);
    end
  end
endmodule

// File: verification/cam_position_switch_tb.sv
`timescale 1ns/1ps
`include "cps_consts.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module cam_position_switch_tb;
  typedef struct {logic [31:0] pos; logic [31:0] st; logic [31:0] pa; logic [31:0] drv;} cps_row_s;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        servo_tick;
  logic [31:0] axis_position;
  logic [31:0] cam_status;
  logic [31:0] points_a;
  logic [31:0] points_b;
  logic [31:0] drive_out;
  logic        eval_busy;
  logic        fire;
  logic [31:0] target_pos;
  logic [31:0] rd;
  logic        err;
  cps_row_s    rows [7];
  int          fail_count;
  int          n_tests;
  int          cyc;
  cps_top u_cps_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .servo_tick(servo_tick), .axis_position(axis_position), .selected_axis(8'h01),
    .cam_status(cam_status), .points_a(points_a), .points_b(points_b), .drive_out(drive_out),
    .eval_busy(eval_busy));
  cps_axis_src u_cps_axis_src (.pclk(pclk), .presetn(presetn), .fire(fire), .target_pos(target_pos),
    .servo_tick(servo_tick), .axis_position(axis_position));
  // ----------------------------------------
  // clock, timeout, closing
  // ----------------------------------------
  always #5 pclk = ~pclk;
  // whole run needs well under 5000 cycles; ceiling leaves margin
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      $display("ERROR timeout expected %h seen %h", 0, cyc);
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // bus and sweep helpers
  // ----------------------------------------
  // setup one edge after entry, so two transfers never assign psel twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cfg(input logic [4:0] e, input logic [31:0] on, input logic [31:0] off, input logic [31:0] m);
    apb(1'b1, `CPS_REG_ENTRY_SEL, {27'h0, e});
    apb(1'b1, `CPS_REG_ON_POS, on);
    apb(1'b1, `CPS_REG_OFF_POS, off);
    apb(1'b1, `CPS_REG_MODULE, m);
    apb(1'b1, `CPS_REG_COMMIT, 32'h00000001);
  endtask
  task automatic sweep(input logic [31:0] p);
    int k;
    @(posedge pclk);
    target_pos <= p;
    fire       <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    k = 0;
    while (eval_busy !== 1'b1 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    while (eval_busy !== 1'b0 && k < 200) begin
      @(posedge pclk);
      k++;
    end
    `CHK("sweep_bound", 1'b1, k < 200)
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    fire = 0; target_pos = 0; fail_count = 0; n_tests = 0; cyc = 0;
    rows = '{'{32'd50, 32'h22, 32'h0, 32'h2}, '{32'd100, 32'h21, 32'h8, 32'h2}, '{32'd199, 32'h21, 32'h8, 32'h2},
      '{32'd200, 32'h22, 32'h0, 32'h2}, '{32'd650, 32'h42, 32'h0, 32'h4}, '{32'd1050, 32'h22, 32'h0, 32'h2},
      '{32'd999, 32'h02, 32'h0, 32'h0}};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    `CHK("reset_status", 32'h0, cam_status)
    // rollover first, then entries; codes 0, 2 and 101..232 only, unique channels
    apb(1'b1, `CPS_REG_ROLLOVER, 32'd1000);
    apb(1'b1, `CPS_REG_CTRL, 32'h00000001);
    cfg(5'd0, 32'd100, 32'd200, 32'h00000302);
    cfg(5'd1, 32'd200, 32'd100, 32'h00000000);
    cfg(5'd2, 32'd300, 32'd300, 32'h00000502);
    cfg(5'd3, 32'd0, 32'd999, 32'h00010602);
    cfg(5'd5, 32'd0, 32'd500, 32'h00000165);
    cfg(5'd6, 32'd600, 32'd700, 32'h00000296);
    apb(1'b0, `CPS_REG_COMMIT, 32'h0);
    `CHK("commit_ok", 32'h1, rd & 32'h1)
    for (int i = 0; i < 7; i++) begin
      sweep(rows[i].pos);
      `CHK("cam_status", rows[i].st, cam_status)
      `CHK("points_a", rows[i].pa, points_a)
      `CHK("drive_out", rows[i].drv, drive_out)
      `CHK("points_b", 32'h0, points_b)
    end
    $display("test table done");
    cfg(5'd4, 32'hDFFFFFFF, 32'd10, 32'h00000702);
    apb(1'b0, `CPS_REG_VALID, 32'h0);
    `CHK("commit_low", 32'h0, rd & 32'h10)
    apb(1'b0, `CPS_REG_COMMIT, 32'h0);
    `CHK("commit_low_flag", 32'h0, rd & 32'h1)
    cfg(5'd4, 32'd10, 32'h20000000, 32'h00000702);
    apb(1'b0, `CPS_REG_COMMIT, 32'h0);
    `CHK("commit_high_flag", 32'h0, rd & 32'h1)
    apb(1'b0, `CPS_REG_VALID, 32'h0);
    `CHK("valid_entry4", 32'h0, rd & 32'h10)
    apb(1'b0, 12'h0FC, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    `CHK("unmapped_err", 1'b0, err)
    $display("test refusal done");
    // inhibit an entry whose output is on: both status and point must drop
    sweep(32'd150);
    `CHK("on_before", 32'h8, points_a)
    cfg(5'd0, 32'd100, 32'd200, 32'h00010302);
    sweep(32'd150);
    `CHK("inh_status", 32'h20, cam_status)
    `CHK("inh_point", 32'h0, points_a)
    $display("test inhibit done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK("rst_status", 32'h0, cam_status)
    `CHK("rst_drive", 32'h0, drive_out)
    presetn <= 1'b1;
    apb(1'b1, `CPS_REG_ROLLOVER, 32'd1000);
    apb(1'b1, `CPS_REG_CTRL, 32'h00000001);
    sweep(32'd150);
    `CHK("unconf_status", 32'h0, cam_status)
    `CHK("unconf_points", 32'h0, points_a | drive_out)
    // only one physical code after reset, so bank b may be used on its own
    cfg(5'd7, 32'd100, 32'd200, 32'h00000404);
    sweep(32'd150);
    `CHK("bank_b_status", 32'h80, cam_status)
    `CHK("bank_b_point", 32'h10, points_b)
    `CHK("bank_b_other", 32'h0, points_a | drive_out)
    $display("test reset done");
    complete_run();
  end
endmodule
